// ==== hfs_pkg.sv ====
/*
  constants and carrier types for the hdlc status, control and interrupt block.
  assumes a single clock domain and an 8-bit parallel register port.
*/
`default_nettype none
package hfs_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_TX_DATA = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_CTRL2 = 5'h15;
  localparam logic [4:0] OFS_MASK = 5'h16;
  localparam logic [4:0] OFS_FLAGS = 5'h17;
  localparam logic [4:0] OFS_TX_COUNT = 5'h1a;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_INTSEL = 7;
  localparam int CTL_CYCLE = 6;
  localparam int CTL_TCRCI = 5;
  localparam int CTL_SEVEN = 4;
  localparam int CTL_RXFRST = 1;
  localparam int CTL_TXFRST = 0;
  localparam logic [7:0] CTRL2_WMASK = 8'hf3;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam int INT_GA = 7;
  localparam int INT_RX_PACKET_END_WRITTEN = 6;
  localparam int INT_TX_PACKET_DONE = 5;
  localparam int INT_RX_LAST_BYTE_NEXT = 4;
  localparam int INT_TXLOW = 3;
  localparam int INT_ABORT = 2;
  localparam int INT_RXHIGH = 1;
  localparam int INT_OVFL = 0;
  localparam int STS_INTGEN = 7;
  localparam int STS_IDLE = 6;
  // ----------------------------------------------------------------
  // sizes and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RX_DEPTH = 8'h80;
  localparam logic [4:0] ABORT_MIN_BITS = 5'h1a;
  localparam int TX_DEPTH = 8;
  localparam int TX_CNT_W = 4;
  localparam logic [1:0] RXS_EMPTY = 2'h0;
  localparam logic [1:0] RXS_LOW = 2'h1;
  localparam logic [1:0] RXS_LEVEL = 2'h2;
  localparam logic [1:0] RXS_INT = 2'h3;
  localparam logic [1:0] TXS_LEVEL = 2'h0;
  localparam logic [1:0] TXS_INT = 2'h1;
  localparam logic [1:0] TXS_EMPTY = 2'h2;
  localparam logic [1:0] TXS_LOW = 2'h3;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HFS_RX_ON = 2'b01,
    HFS_RX_WAIT_FLAG = 2'b10
  } hfs_rx_state_e;
  typedef struct packed {
    logic [7:0] data;
    logic packet_end_tag;
    logic append_fcs;
  } hfs_tx_word_s;
  localparam int TX_WORD_W = 10;
endpackage : hfs_pkg
`default_nettype wire

// ==== hfs_fifo.sv ====
/*
  flip-flop fifo with valid/ready on both sides and a pointer flush.
  assumes the flush never needs to clear the stored words.
*/
`default_nettype none
module hfs_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8,
  parameter int CW = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;
  assign in_ready = (count_q != FULL);
  assign out_valid = (count_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_ptr_q];
  assign count = count_q;
  // ----------------------------------------------------------------
  // storage, kept across a flush
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end
  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end
endmodule : hfs_fifo
`default_nettype wire

// ==== hfs_top.sv ====
/*
  hdlc status, control and interrupt block with transmit fifo and byte counter.
  assumes one clock, synchronous strobes from the register port, and an
  external receive fifo and serial engine that report counts and events.
*/
// Behaviour
// - rx fill state codes empty, low, level, threshold
// - intsel picks underrun or abort for bit 2
// - cycle bit reloads byte count continuously
// - crc inhibit drops fcs after end byte
// - seven bit address mode to receiver
// - rx fifo reset: empty status, receiver waits flag
// - tx fifo reset empties, self-clears on write
// - masked sources still latch, no request
// - mask zero disables, mask resets to zero
// - bit 7 on go-ahead pattern
// - bit 6 on end byte written to rx
// - bit 5 on closing flag or abort sent
// - bit 4 on last byte next or empty read
// - bit 3 when tx fill drops below low
// - bit 2 on abort after 26 bits
// - bit 2 on fetch from empty tx fifo
// - bit 1 when rx fills above full level
// - bit 0 and receiver off on overflow
// - receiver back on at next flag
// - interrupt register clears when read
// - status bit 7 on unmasked event, interrupt register read clears
// - count of one tags next write as end
`default_nettype none
module hfs_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cpu_cs,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [4:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic irq,
  output logic tx_space,
  input wire logic go_ahead_seen,
  input wire logic rx_packet_end_written,
  input wire logic tx_packet_done,
  input wire logic rx_last_byte_next,
  input wire logic frame_abort_seen,
  input wire logic rx_bit_strobe,
  input wire logic rx_flag_seen,
  input wire logic rx_write_attempt,
  input wire logic rx_fifo_read,
  input wire logic rx_idle_channel,
  input wire logic [1:0] rx_byte_status,
  input wire logic [7:0] rx_count,
  input wire logic [7:0] rx_status_level,
  input wire logic [7:0] rx_int_level,
  input wire logic [7:0] rx_full_level,
  input wire logic [3:0] tx_status_level,
  input wire logic [3:0] tx_int_level,
  input wire logic [3:0] tx_low_level,
  input wire logic tx_fetch,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_packet_end,
  output logic tx_append_fcs,
  output logic rx_enable,
  output logic rx_seven_bit_addr,
  output logic rx_fifo_flush
);
  logic [7:0] ctrl2_q;
  logic [7:0] mask_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] events;
  logic intgen_q;
  logic irq_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_prog_q;
  logic [7:0] rdata_q;
  logic [4:0] rx_bits_q;
  logic rx_forced_empty_q;
  logic rx_flush_q;
  hfs_pkg::hfs_rx_state_e rx_state_q;
  logic [7:0] rx_count_prev_q;
  logic [3:0] tx_cnt_prev_q;
  hfs_pkg::hfs_tx_word_s tx_word_q;
  hfs_pkg::hfs_tx_word_s fifo_in;
  hfs_pkg::hfs_tx_word_s fifo_out;
  logic tx_valid_q;
  logic tx_space_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [3:0] tx_cnt;
  logic tx_flush;
  logic wr_hit;
  logic rd_hit;
  logic tx_wr;
  logic flags_rd;
  logic abort_ev;
  logic underrun_ev;
  logic ovfl_ev;
  logic [1:0] rx_state_code;
  logic [1:0] tx_state_code;
  logic [7:0] status_word;

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign wr_hit = cpu_cs && cpu_wr;
  assign rd_hit = cpu_cs && cpu_rd;
  assign tx_wr = wr_hit && hit(cpu_addr, hfs_pkg::OFS_TX_DATA);
  assign flags_rd = rd_hit && hit(cpu_addr, hfs_pkg::OFS_FLAGS);

  // ----------------------------------------------------------------
  // control register two
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl2_q <= hfs_pkg::CTRL2_RST;
    end else if (wr_hit && hit(cpu_addr, hfs_pkg::OFS_CTRL2)) begin
      ctrl2_q <= cpu_wdata & hfs_pkg::CTRL2_WMASK;
    end else if (tx_wr) begin
      ctrl2_q[hfs_pkg::CTL_TXFRST] <= 1'b0;
    end
  end

  assign tx_flush = wr_hit && hit(cpu_addr, hfs_pkg::OFS_CTRL2)
                    && cpu_wdata[hfs_pkg::CTL_TXFRST];

  // ----------------------------------------------------------------
  // mask register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mask_q <= hfs_pkg::MASK_RST;
    end else if (wr_hit && hit(cpu_addr, hfs_pkg::OFS_MASK)) begin
      mask_q <= cpu_wdata;
    end
  end

  // ----------------------------------------------------------------
  // transmit byte counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= hfs_pkg::COUNT_RST;
      cnt_prog_q <= hfs_pkg::COUNT_RST;
    end else if (wr_hit && hit(cpu_addr, hfs_pkg::OFS_TX_COUNT)) begin
      cnt_q <= cpu_wdata;
      cnt_prog_q <= cpu_wdata;
    end else if (tx_wr && fifo_in_ready) begin
      if (cnt_q == 8'h01) begin
        cnt_q <= ctrl2_q[hfs_pkg::CTL_CYCLE] ? cnt_prog_q : 8'h00;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit fifo and output stage
  // ----------------------------------------------------------------
  always_comb begin
    fifo_in.data = cpu_wdata;
    fifo_in.packet_end_tag = (cnt_q == 8'h01);
    fifo_in.append_fcs = (cnt_q == 8'h01) && !ctrl2_q[hfs_pkg::CTL_TCRCI];
  end

  assign fifo_out_ready = !tx_valid_q || tx_fetch;

  hfs_fifo #(
    .WIDTH(hfs_pkg::TX_WORD_W),
    .DEPTH(hfs_pkg::TX_DEPTH),
    .CW(hfs_pkg::TX_CNT_W)
  ) u_tx_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(tx_flush),
    .in_valid(tx_wr),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out),
    .count(tx_cnt)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst || tx_flush) begin
      tx_valid_q <= 1'b0;
      tx_word_q <= '0;
    end else if (fifo_out_ready) begin
      tx_valid_q <= fifo_out_valid;
      if (fifo_out_valid) begin
        tx_word_q <= fifo_out;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_space_q <= 1'b0;
      tx_cnt_prev_q <= '0;
    end else begin
      tx_space_q <= (tx_cnt < 4'(hfs_pkg::TX_DEPTH - 1));
      tx_cnt_prev_q <= tx_cnt;
    end
  end

  // ----------------------------------------------------------------
  // receiver enable and abort bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_state_q <= hfs_pkg::HFS_RX_ON;
    end else begin
      unique case (rx_state_q)
        hfs_pkg::HFS_RX_ON: begin
          if (ovfl_ev || rx_flush_q) begin
            rx_state_q <= hfs_pkg::HFS_RX_WAIT_FLAG;
          end
        end
        hfs_pkg::HFS_RX_WAIT_FLAG: begin
          if (rx_flag_seen && !ovfl_ev) begin
            rx_state_q <= hfs_pkg::HFS_RX_ON;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_flush_q <= 1'b0;
      rx_forced_empty_q <= 1'b0;
    end else begin
      rx_flush_q <= wr_hit && hit(cpu_addr, hfs_pkg::OFS_CTRL2)
                    && cpu_wdata[hfs_pkg::CTL_RXFRST];
      if (rx_flush_q) begin
        rx_forced_empty_q <= 1'b1;
      end else if (rx_flag_seen) begin
        rx_forced_empty_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || rx_flag_seen) begin
      rx_bits_q <= '0;
    end else if (rx_bit_strobe && rx_bits_q != hfs_pkg::ABORT_MIN_BITS) begin
      rx_bits_q <= rx_bits_q + 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_count_prev_q <= '0;
    end else begin
      rx_count_prev_q <= rx_count;
    end
  end

  // ----------------------------------------------------------------
  // interrupt events and flags
  // ----------------------------------------------------------------
  assign abort_ev = frame_abort_seen && (rx_bits_q == hfs_pkg::ABORT_MIN_BITS);
  assign underrun_ev = tx_fetch && !tx_valid_q;
  assign ovfl_ev = rx_write_attempt && (rx_count >= hfs_pkg::RX_DEPTH);

  always_comb begin
    events = '0;
    events[hfs_pkg::INT_GA] = go_ahead_seen;
    events[hfs_pkg::INT_RX_PACKET_END_WRITTEN] = rx_packet_end_written;
    events[hfs_pkg::INT_TX_PACKET_DONE] = tx_packet_done;
    events[hfs_pkg::INT_RX_LAST_BYTE_NEXT] = rx_last_byte_next
                                || (rx_fifo_read && rx_count == 8'h00);
    events[hfs_pkg::INT_TXLOW] = (tx_cnt < tx_low_level)
                                 && (tx_cnt_prev_q >= tx_low_level);
    events[hfs_pkg::INT_ABORT] = ctrl2_q[hfs_pkg::CTL_INTSEL] ? underrun_ev : abort_ev;
    events[hfs_pkg::INT_RXHIGH] = (rx_count > rx_full_level)
                                  && (rx_count_prev_q <= rx_full_level);
    events[hfs_pkg::INT_OVFL] = ovfl_ev;
  end

  // set wins over the clear by read
  assign flags_d = (flags_rd ? 8'h00 : flags_q) | events;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flags_q <= hfs_pkg::FLAGS_RST;
      intgen_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      intgen_q <= (flags_rd ? 1'b0 : intgen_q) || ((events & mask_q) != 8'h00);
      irq_q <= (flags_d & mask_q) != 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // status word and read data
  // ----------------------------------------------------------------
  always_comb begin
    if (rx_forced_empty_q || rx_count == 8'h00) begin
      rx_state_code = hfs_pkg::RXS_EMPTY;
    end else if (rx_count >= rx_int_level) begin
      rx_state_code = hfs_pkg::RXS_INT;
    end else if (rx_count >= rx_status_level) begin
      rx_state_code = hfs_pkg::RXS_LEVEL;
    end else begin
      rx_state_code = hfs_pkg::RXS_LOW;
    end
    if (tx_cnt == 4'h0) begin
      tx_state_code = hfs_pkg::TXS_EMPTY;
    end else if (tx_cnt >= tx_int_level) begin
      tx_state_code = hfs_pkg::TXS_INT;
    end else if (tx_cnt >= tx_status_level) begin
      tx_state_code = hfs_pkg::TXS_LEVEL;
    end else begin
      tx_state_code = hfs_pkg::TXS_LOW;
    end
    status_word = {intgen_q, rx_idle_channel, rx_byte_status, tx_state_code, rx_state_code};
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (rd_hit) begin
      unique case (cpu_addr)
        hfs_pkg::OFS_STATUS: rdata_q <= status_word;
        hfs_pkg::OFS_CTRL2: rdata_q <= ctrl2_q;
        hfs_pkg::OFS_MASK: rdata_q <= mask_q;
        hfs_pkg::OFS_FLAGS: rdata_q <= flags_q;
        hfs_pkg::OFS_TX_COUNT: rdata_q <= cnt_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cpu_rdata = rdata_q;
  assign irq = irq_q;
  assign tx_space = tx_space_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_word_q.data;
  assign tx_packet_end = tx_word_q.packet_end_tag;
  assign tx_append_fcs = tx_word_q.append_fcs;
  assign rx_enable = rx_state_q[0];
  assign rx_seven_bit_addr = ctrl2_q[hfs_pkg::CTL_SEVEN];
  assign rx_fifo_flush = rx_flush_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_ovfl_disables;
    @(posedge mclk) disable iff (sys_rst)
    ovfl_ev |=> !rx_enable && flags_q[hfs_pkg::INT_OVFL];
  endproperty
  a_ovfl_disables: assert property (p_ovfl_disables)
    else $error("overflow did not latch or disable receiver");

  property p_flag_reenables;
    @(posedge mclk) disable iff (sys_rst)
    !rx_enable && rx_flag_seen && !ovfl_ev |=> rx_enable;
  endproperty
  a_flag_reenables: assert property (p_flag_reenables)
    else $error("receiver not re-enabled by flag");

  property p_read_clears;
    @(posedge mclk) disable iff (sys_rst)
    flags_rd && events == 8'h00 |=> flags_q == 8'h00 && !intgen_q;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("interrupt register not cleared by read");

  property p_irq_masked;
    @(posedge mclk) disable iff (sys_rst)
    ##1 irq == ((flags_q & $past(mask_q)) != 8'h00);
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt request disagrees with flags and mask");

  property p_early_abort_ignored;
    @(posedge mclk) disable iff (sys_rst)
    frame_abort_seen && rx_bits_q < hfs_pkg::ABORT_MIN_BITS && !ctrl2_q[hfs_pkg::CTL_INTSEL]
    && !flags_q[hfs_pkg::INT_ABORT] |=> !flags_q[hfs_pkg::INT_ABORT];
  endproperty
  a_early_abort_ignored: assert property (p_early_abort_ignored)
    else $error("abort before minimum bits was latched");

  property p_underrun_sel;
    @(posedge mclk) disable iff (sys_rst)
    ctrl2_q[hfs_pkg::CTL_INTSEL] && tx_fetch && !tx_valid |=> flags_q[hfs_pkg::INT_ABORT];
  endproperty
  a_underrun_sel: assert property (p_underrun_sel)
    else $error("underrun not latched in bit 2");

  property p_txfrst_selfclear;
    @(posedge mclk) disable iff (sys_rst)
    ctrl2_q[hfs_pkg::CTL_TXFRST] && tx_wr |=> !ctrl2_q[hfs_pkg::CTL_TXFRST];
  endproperty
  a_txfrst_selfclear: assert property (p_txfrst_selfclear)
    else $error("tx fifo reset bit did not self-clear");

  property p_count_reload;
    @(posedge mclk) disable iff (sys_rst)
    tx_wr && fifo_in_ready && cnt_q == 8'h01 && ctrl2_q[hfs_pkg::CTL_CYCLE]
    |=> cnt_q == $past(cnt_prog_q);
  endproperty
  a_count_reload: assert property (p_count_reload)
    else $error("byte counter did not reload in cycle mode");

  property p_mask_reset;
    @(posedge mclk) $fell(sys_rst) |-> mask_q == 8'h00 && !irq;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask not zero after reset");

  property p_rx_empty_status;
    @(posedge mclk) disable iff (sys_rst)
    rx_flush_q |=> rx_state_code == hfs_pkg::RXS_EMPTY;
  endproperty
  a_rx_empty_status: assert property (p_rx_empty_status)
    else $error("rx status not empty after fifo reset");
endmodule : hfs_top
`default_nettype wire

// ==== hfs_cpu_model.sv ====
/*
  microprocessor model on the parallel register port of hfs_top.
  assumes inputs are sampled on the rising mclk edge; drives on falling edges.
*/
`default_nettype none
module hfs_cpu_model (
  input wire logic mclk,
  output logic cpu_cs,
  output logic cpu_rd,
  output logic cpu_wr,
  output logic [4:0] cpu_addr,
  output logic [7:0] cpu_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cpu_cs = 1'b0;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_addr = 5'h00;
    cpu_wdata = 8'h00;
  end
  // ----------------------------------------------------------------
  // one access: held across one rising edge, then released
  // ----------------------------------------------------------------
  task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(negedge mclk);
    cpu_cs = 1'b1;
    cpu_wr = w;
    cpu_rd = !w;
    cpu_addr = a;
    cpu_wdata = (a == hfs_pkg::OFS_CTRL2) ? (d & 8'hf3) : d;
    @(negedge mclk);
    cpu_cs = 1'b0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_addr = ~a;
    cpu_wdata = ~cpu_wdata;
  endtask : access
endmodule : hfs_cpu_model
`default_nettype wire

// ==== tb_hfs_top.sv ====
/*
  self-checking bench for hfs_top: register port, event flags, tx fifo path.
  assumes hfs_cpu_model drives the register port; other inputs driven here.
*/
`default_nettype none
module tb_hfs_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] TXD = hfs_pkg::OFS_TX_DATA;
  localparam logic [4:0] ST = hfs_pkg::OFS_STATUS;
  localparam logic [4:0] C2 = hfs_pkg::OFS_CTRL2;
  localparam logic [4:0] MK = hfs_pkg::OFS_MASK;
  localparam logic [4:0] FL = hfs_pkg::OFS_FLAGS;
  localparam logic [4:0] CNT = hfs_pkg::OFS_TX_COUNT;
  logic mclk = 1'b0, sys_rst = 1'b1, rd_pend = 1'b0, rx_idle_channel = 1'b0;
  logic cpu_cs, cpu_rd, cpu_wr, irq, tx_space, tx_valid, tx_packet_end, tx_append_fcs;
  logic rx_enable, rx_seven_bit_addr, rx_fifo_flush;
  logic [1:0] rx_byte_status = 2'h0;
  logic [4:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, tx_data, rx_count = 8'h00, rx_full_level = 8'h7f;
  logic [7:0] rx_status_level = 8'h10, rx_int_level = 8'h40;
  logic [3:0] tx_status_level = 4'h6, tx_int_level = 4'h3, tx_low_level = 4'h4;
  logic [9:0] ev = 10'h000;
  logic [31:0] seed = 32'hec12c190;
  logic [9:0] rdq[$], txq[$];
  int n_fail = 0, tests_run = 0;
  wire go_ahead_seen = ev[0], rx_packet_end_written = ev[1], tx_packet_done = ev[2],
    rx_last_byte_next = ev[3], frame_abort_seen = ev[4], rx_bit_strobe = ev[5],
    rx_flag_seen = ev[6], rx_write_attempt = ev[7], rx_fifo_read = ev[8], tx_fetch = ev[9];
  hfs_top hfs_top_i (.mclk, .sys_rst, .cpu_cs, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata,
    .cpu_rdata, .irq, .tx_space, .go_ahead_seen, .rx_packet_end_written, .tx_packet_done,
    .rx_last_byte_next, .frame_abort_seen, .rx_bit_strobe, .rx_flag_seen, .rx_write_attempt,
    .rx_fifo_read, .rx_idle_channel, .rx_byte_status, .rx_count, .rx_status_level,
    .rx_int_level, .rx_full_level, .tx_status_level, .tx_int_level, .tx_low_level, .tx_fetch,
    .tx_valid, .tx_data, .tx_packet_end, .tx_append_fcs, .rx_enable, .rx_seven_bit_addr,
    .rx_fifo_flush);
  hfs_cpu_model cpu_i (.mclk, .cpu_cs, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata);
  always #2 mclk = ~mclk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("mismatches %0d of %0d compares", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  function automatic void nx();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction : nx
  function automatic logic [7:0] sts(input logic ig);
    logic [1:0] rc;
    rc = (rx_count == 8'h00) ? 2'h0 : (rx_count >= rx_int_level) ? 2'h3 :
      (rx_count >= rx_status_level) ? 2'h2 : 2'h1;
    return {ig, rx_idle_channel, rx_byte_status, 2'h2, rc};
  endfunction : sts
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cpu_i.access(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rdq.push_back({2'h0, e});
    cpu_i.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic pulse(input int b);
    @(negedge mclk);
    ev[b] = 1'b1;
    @(negedge mclk);
    ev[b] = 1'b0;
  endtask : pulse
  // compare oldest noted result when a read or a fetch completes
  always @(posedge mclk) begin
    if (rd_pend) chk({2'h0, cpu_rdata}, rdq.pop_front());
    if (tx_valid && tx_fetch) chk({tx_data, tx_packet_end, tx_append_fcs}, txq.pop_front());
    rd_pend <= cpu_cs & cpu_rd;
  end
  initial begin
    #40000;
    n_fail++;
    close_out();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    rd(C2, 8'h00);
    rd(MK, 8'h00);
    rd(FL, 8'h00);
    wr(MK, 8'h80);
    pulse(1);
    @(negedge mclk);
    chk({9'h0, irq}, 10'h0);
    pulse(0);
    @(negedge mclk);
    chk({9'h0, irq}, 10'h1);
    rd(ST, sts(1'b1));
    rd(FL, 8'hc0);
    repeat (2) @(negedge mclk);
    chk({9'h0, irq}, 10'h0);
    rd(ST, sts(1'b0));
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      rd(FL, 8'h80 >> i);
    end
    pulse(8);
    rd(FL, 8'h10);
    pulse(6);
    repeat (25) pulse(5);
    pulse(4);
    rd(FL, 8'h00);
    pulse(6);
    repeat (26) pulse(5);
    pulse(4);
    rd(FL, 8'h04);
    repeat (20) begin
      nx();
      rx_count = {1'b0, seed[6:0]};
      rx_status_level = seed[15:8];
      rx_int_level = seed[23:16];
      {rx_idle_channel, rx_byte_status} = seed[26:24];
      rd(ST, sts(1'b0));
    end
    rx_count = 8'h80;
    pulse(7);
    chk({9'h0, rx_enable}, 10'h0);
    rd(FL, 8'h03);
    pulse(6);
    @(negedge mclk);
    chk({9'h0, rx_enable}, 10'h1);
    rx_count = 8'h05;
    wr(C2, 8'h02);
    chk({9'h0, rx_fifo_flush}, 10'h1);
    @(negedge mclk);
    chk({8'h0, rx_fifo_flush, rx_enable}, 10'h0);
    rd(ST, sts(1'b0) & 8'hfc);
    pulse(6);
    wr(C2, 8'h1c);
    rd(C2, 8'h10);
    chk({9'h0, rx_seven_bit_addr}, 10'h1);
    wr(C2, 8'hc0);
    wr(CNT, 8'h03);
    for (int i = 1; i < 10; i++) begin
      nx();
      txq.push_back({seed[7:0], i % 3 == 0, i % 3 == 0});
      wr(TXD, seed[7:0]);
    end
    chk({9'h0, tx_space}, 10'h0);
    rd(ST, (sts(1'b0) & 8'hf3) | 8'h04);
    rd(CNT, 8'h03);
    repeat (10) pulse(9);
    rd(FL, 8'h0c);
    wr(C2, 8'he0);
    wr(CNT, 8'h01);
    nx();
    txq.push_back({seed[7:0], 1'b1, 1'b0});
    wr(TXD, seed[7:0]);
    pulse(9);
    wr(TXD, 8'h5a);
    wr(C2, 8'h01);
    rd(ST, sts(1'b0));
    rd(C2, 8'h01);
    wr(TXD, 8'ha5);
    rd(C2, 8'h00);
    @(negedge mclk);
    close_out();
  end
endmodule : tb_hfs_top
`default_nettype wire
